// file: rtl/fbp_port.sv
`timescale 1ns/100ps
module fbp_port
  import fbp_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       arst_n,
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic [7:0] reg_wmask,
  output logic      [7:0] reg_rdata,
  input  wire logic [4:0] pin_in,
  output logic      [4:0] pin_out,
  output logic      [4:0] pin_oe,
  input  wire logic       timer_clk_enable,
  output logic            timer_ext_clock_input
);
  // ------------------------------------------------------------
  // Pin synchronisers and pin image
  // ------------------------------------------------------------
  logic [4:0] sync_a;
  logic [4:0] sync_b;
  logic [4:0] pin_img;
  logic       bit4_filt;
  logic [4:0] latch;
  logic [4:0] dir;

  // Pins change at any time, so two flops settle them before any logic reads them.
  // Only the second flop feeds the pin image and the filter.
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      sync_a <= 5'h00;
      sync_b <= 5'h00;
    end else begin
      sync_a <= pin_in;
      sync_b <= sync_a;
    end
  end

  fbp_schmitt u_schmitt (
    .clk_sys   (clk_sys),
    .arst_n    (arst_n),
    .level_in  (sync_b[FBP_SHARED_BIT]),
    .level_out (bit4_filt)
  );

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pin_img <= FBP_PIN_IMG_RESET;
    end else begin
      pin_img <= {bit4_filt, sync_b[3:0]};
    end
  end

  // The timer sees the filtered level in the same clock as the pin image does.
  // timer clock tap
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      timer_ext_clock_input <= 1'b0;
    end else begin
      timer_ext_clock_input <= bit4_filt;
    end
  end

  // ------------------------------------------------------------
  // Register decode
  // ------------------------------------------------------------
  wire        sel_pins = (reg_addr == FBP_PINS_ADDR);
  wire        sel_dir  = (reg_addr == FBP_DIR_ADDR);
  wire        wr_pins  = reg_wr && sel_pins;
  wire        wr_dir   = reg_wr && sel_dir;
  // Unmasked bits are written back with the sampled pin level, not the old latch value.
  // A pin that an outside circuit holds against its latch therefore loses that latch value.
  // read-modify-write merge
  wire [4:0]  rmw_val  = (pin_img & ~reg_wmask[4:0]) | (reg_wdata[4:0] & reg_wmask[4:0]);
  wire [4:0]  next_latch = wr_pins ? rmw_val : latch;
  wire [4:0]  next_dir   = wr_dir ? reg_wdata[4:0] : dir;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      latch <= FBP_LATCH_RESET;
      dir   <= FBP_DIR_RESET;
    end else begin
      latch <= next_latch;
      dir   <= next_dir;
    end
  end

  wire [7:0] rd_pins = {3'h0, pin_img};
  wire [7:0] rd_dir  = {3'h0, dir};
  assign reg_rdata = sel_pins ? rd_pins : (sel_dir ? rd_dir : 8'h00);

  // ------------------------------------------------------------
  // Pin drivers
  // ------------------------------------------------------------
  // input releases driver
  wire [3:0] low_oe = ~dir[3:0];
  // Bit four only pulls low: a latch one releases the pin to its outside pull-up.
  // open drain bit four
  wire       oe4    = ~dir[4] && ~latch[4] && ~timer_clk_enable;
  assign pin_oe  = {oe4, low_oe};
  assign pin_out = {1'b0, latch[3:0]};

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  // input releases driver
  a_input_released: assert property (@(posedge clk_sys) disable iff (!arst_n)
    dir[0] |-> !pin_oe[0])
    else $error("input pin is driven");

  a_released_all: assert property (@(posedge clk_sys) disable iff (!arst_n)
    (dir & pin_oe) == 5'h00)
    else $error("driver on for an input pin");

  a_output_drives: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !dir[1] |-> pin_oe[1] && pin_out[1] == latch[1])
    else $error("output mismatch");

  a_drive_all: assert property (@(posedge clk_sys) disable iff (!arst_n)
    pin_oe[3:0] == ~dir[3:0] && pin_out[3:0] == latch[3:0])
    else $error("low bits drive wrong");

  // This check runs while reset is held, so it carries no disable clause.
  // reset leaves inputs
  a_reset_inputs: assert property (@(posedge clk_sys)
    !arst_n |=> dir == FBP_DIR_RESET && pin_img == FBP_PIN_IMG_RESET && pin_oe == 5'h00)
    else $error("reset state wrong");

  a_pins_read: assert property (@(posedge clk_sys) disable iff (!arst_n)
    sel_pins |-> reg_rdata == {3'h0, pin_img})
    else $error("pin read wrong");

  a_unmapped_zero: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !sel_pins && !sel_dir |-> reg_rdata == 8'h00)
    else $error("unmapped read nonzero");

  a_rmw_store: assert property (@(posedge clk_sys) disable iff (!arst_n)
    wr_pins |=> latch == $past(rmw_val))
    else $error("latch not loaded");

  a_rmw_keeps: assert property (@(posedge clk_sys) disable iff (!arst_n)
    wr_pins |=> (latch & ~$past(reg_wmask[4:0])) == ($past(pin_img) & ~$past(reg_wmask[4:0])))
    else $error("unmasked bit not from pins");

  a_rmw_sets: assert property (@(posedge clk_sys) disable iff (!arst_n)
    wr_pins |=> (latch & $past(reg_wmask[4:0])) ==
                ($past(reg_wdata[4:0]) & $past(reg_wmask[4:0])))
    else $error("masked bit not written");

  a_drain_only_low: assert property (@(posedge clk_sys) disable iff (!arst_n)
    pin_oe[4] |-> !pin_out[4])
    else $error("bit four drives high");

  a_drain_release: assert property (@(posedge clk_sys) disable iff (!arst_n)
    latch[4] |-> !pin_oe[4])
    else $error("bit four not released");

  a_bit_four_low: assert property (@(posedge clk_sys) disable iff (!arst_n)
    pin_out[FBP_SHARED_BIT] == 1'b0)
    else $error("bit four drive value high");

  a_timer_follows: assert property (@(posedge clk_sys) disable iff (!arst_n)
    timer_ext_clock_input == $past(bit4_filt))
    else $error("timer clock out of step");

  a_filter_steady: assert property (@(posedge clk_sys) disable iff (!arst_n)
    $changed(bit4_filt) |->
      $past(sync_b[FBP_SHARED_BIT], 1) == bit4_filt &&
      $past(sync_b[FBP_SHARED_BIT], 2) == bit4_filt &&
      $past(sync_b[FBP_SHARED_BIT], 3) == bit4_filt)
    else $error("filter moved early");

  a_shared_reserved: assert property (@(posedge clk_sys) disable iff (!arst_n)
    timer_clk_enable |-> !pin_oe[4])
    else $error("shared pin driven");

  a_dir_upper_zero: assert property (@(posedge clk_sys) disable iff (!arst_n)
    sel_dir |-> reg_rdata[7:5] == 3'h0)
    else $error("upper bits nonzero");

  a_latch_holds: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !wr_pins |=> $stable(latch))
    else $error("latch changed");

  a_dir_write: assert property (@(posedge clk_sys) disable iff (!arst_n)
    wr_dir |=> dir == $past(reg_wdata[4:0]))
    else $error("dir not written");

  a_dir_holds: assert property (@(posedge clk_sys) disable iff (!arst_n)
    !wr_dir |=> $stable(dir))
    else $error("dir changed");

  a_dir_read: assert property (@(posedge clk_sys) disable iff (!arst_n)
    sel_dir |-> reg_rdata == {3'h0, dir})
    else $error("dir read wrong");

  // ------------------------------------------------------------
  // Scenario covers
  // ------------------------------------------------------------
  c_pin_write: cover property (@(posedge clk_sys) disable iff (!arst_n) wr_pins);
  c_dir_output: cover property (@(posedge clk_sys) disable iff (!arst_n) wr_dir ##1 !dir[0]);
  c_drain_low: cover property (@(posedge clk_sys) disable iff (!arst_n) pin_oe[4]);
  c_rmw_keep: cover property (@(posedge clk_sys) disable iff (!arst_n)
    wr_pins && reg_wmask[4:0] != 5'h1F);
  c_timer_clock: cover property (@(posedge clk_sys) disable iff (!arst_n)
    $rose(timer_ext_clock_input));
endmodule

// file: rtl/fbp_pkg.sv
// Behaviour
// - Five independent two-way pins, each with a latch bit and a direction bit.
// - Direction bit at one makes the pin an input with its driver released.
// - Direction bit at zero drives the pin from its latch bit.
// - After reset all pins are inputs and the pin image reads zero.
// - Data reads return pin levels; data writes load the latch, not the pins.
// - Each data write samples the pins, merges the new bits, then stores the result.
// - Bit four feeds the timer clock through hysteresis and only ever drives low.
// - While the shared timer clock is enabled, bit four is never driven, though its level still reads in the pin image.
// - Direction bits seven to five read as zero and ignore writes.
package fbp_pkg;
  localparam int         FBP_WIDTH          = 5;
  localparam logic [7:0] FBP_PINS_ADDR      = 8'h05;
  localparam logic [7:0] FBP_DIR_ADDR       = 8'h85;
  localparam logic [4:0] FBP_DIR_RESET      = 5'h1F;
  localparam logic [4:0] FBP_LATCH_RESET    = 5'h00;
  localparam logic [4:0] FBP_PIN_IMG_RESET  = 5'h00;
  localparam int         FBP_SHARED_BIT     = 4;
endpackage

// file: rtl/fbp_schmitt.sv
`timescale 1ns/100ps
// Hysteresis filter: the output changes only after the input holds for three samples.
module fbp_schmitt
  import fbp_pkg::*;
(
  input  wire logic clk_sys,
  input  wire logic arst_n,
  input  wire logic level_in,
  output logic      level_out
);
  logic [1:0] hist;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      hist      <= 2'h0;
      level_out <= 1'b0;
    end else begin
      hist <= {hist[0], level_in};
      if (hist[1] == hist[0] && hist[0] == level_in) begin
        level_out <= level_in;
      end
    end
  end
endmodule

// file: verif/fbp_pin_model.sv
`timescale 1ns/100ps
module fbp_pin_model
  import fbp_pkg::*;
(
  input  wire logic [4:0] pin_out,
  input  wire logic [4:0] pin_oe,
  input  wire logic [4:0] ext_val,
  output logic      [4:0] pin_level
);
  // released pins follow the outside level.
  assign pin_level = (pin_oe & pin_out) | (~pin_oe & ext_val);
endmodule

// file: verif/five_bit_bidir_port_tb_top.sv
`timescale 1ns/100ps
module five_bit_bidir_port_tb_top
  import fbp_pkg::*;
;
  logic       clk_sys, arst_n, reg_wr, timer_clk_enable, timer_ext_clock_input;
  logic [7:0] reg_addr, reg_wdata, reg_wmask, reg_rdata;
  logic [4:0] pin_in, pin_out, pin_oe, ext_val;
  int         fails, compares;
  always #50 clk_sys = ~clk_sys;
  fbp_port DUT (.clk_sys(clk_sys), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_wmask(reg_wmask), .reg_rdata(reg_rdata), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .timer_clk_enable(timer_clk_enable),
    .timer_ext_clock_input(timer_ext_clock_input));
  fbp_pin_model PINS (.pin_out(pin_out), .pin_oe(pin_oe), .ext_val(ext_val), .pin_level(pin_in));
  task automatic end_sim();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [7:0] m);
    @(posedge clk_sys);
    reg_addr <= a; reg_wdata <= d; reg_wmask <= m; reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    @(negedge clk_sys);
    chk(reg_rdata, exp);
  endtask
  // ----------
  // Scenarios
  // ----------
  task automatic t_reset();
    rdchk(FBP_DIR_ADDR, 8'h1F);
    rdchk(FBP_PINS_ADDR, 8'h00);
    chk({3'h0, pin_oe}, 8'h00);
  endtask
  task automatic t_dir();
    wr(FBP_DIR_ADDR, 8'hFF, 8'hFF);
    rdchk(FBP_DIR_ADDR, 8'h1F);
    wr(FBP_PINS_ADDR, 8'h0A, 8'hFF);
    @(negedge clk_sys);
    chk({3'h0, pin_oe}, 8'h00);
    wr(FBP_DIR_ADDR, 8'h00, 8'hFF);
    repeat (4) @(posedge clk_sys);
    chk({3'h0, pin_oe}, 8'h1F);
    chk({4'h0, pin_out[3:0]}, 8'h0A);
    rdchk(FBP_PINS_ADDR, 8'h0A);
  endtask
  task automatic t_rmw();
    ext_val <= 5'h05;
    wr(FBP_DIR_ADDR, 8'h0F, 8'hFF);
    repeat (4) @(posedge clk_sys);
    rdchk(FBP_PINS_ADDR, 8'h05);
    wr(FBP_PINS_ADDR, 8'h10, 8'h10);
    ext_val <= 5'h1A;
    wr(FBP_DIR_ADDR, 8'h00, 8'hFF);
    @(negedge clk_sys);
    chk({4'h0, pin_out[3:0]}, 8'h05);
    chk({7'h0, pin_oe[4] | pin_out[4]}, 8'h00);
    for (int i = 0; i < 20 && timer_ext_clock_input !== 1'b1; i++) @(posedge clk_sys);
    chk({7'h0, timer_ext_clock_input}, 8'h01);
    if (timer_ext_clock_input !== 1'b1) return;
    timer_clk_enable <= 1'b1;
    wr(FBP_PINS_ADDR, 8'h00, 8'hFF);
    @(negedge clk_sys);
    chk({7'h0, pin_oe[4]}, 8'h00);
  endtask
  initial begin
    clk_sys = 1'b0; arst_n = 1'b0; reg_wr = 1'b0; reg_addr = 8'h00; reg_wdata = 8'h00;
    reg_wmask = 8'h00; ext_val = 5'h00; timer_clk_enable = 1'b0; fails = 0; compares = 0;
    repeat (5) @(posedge clk_sys);
    arst_n <= 1'b1;
    t_reset();
    t_dir();
    t_rmw();
    end_sim();
  end
endmodule
